// ---- uart_fifo_irq_frontend.sv ----
// FIFO, trigger and interrupt front end of one UART channel
//
// Summary of operation
// [R1] Driving the channel enable low empties and resets both byte queues.
// [R2] Disabling also drops the rx and tx overflow and rx underflow flags.
// [R3] Reading the data port returns the oldest received byte and removes it.
// [R4] Writing the data port appends the byte to the transmit queue.
// [R5] The write-only rx trigger takes codes 0 to 3 and refuses others.
// [R6] The write-only tx trigger takes codes 1 to 4 and refuses others.
// [R7] Both fill counts read back as four-bit fields writes cannot change.
// [R8] Interrupt is high only with master enable and an enabled flag set.
`include "uart_fifo_cfg.svh"
`timescale 1ns/1ps

module uart_fifo_irq_frontend #(
  parameter int DEPTH = 4
) (
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  wb_cyc_in,
  input  wire logic                  wb_stb_in,
  input  wire logic                  wb_we_in,
  input  wire logic [9:0]            wb_adr_in,
  input  wire logic [3:0]            wb_sel_in,
  input  wire logic [31:0]           wb_dat_in,
  output logic      [31:0]           wb_dat_out,
  output logic                       wb_ack_out,
  input  wire uart_fifo_pkg::rx_byte_s rx_byte_in,
  input  wire logic                  tx_take_in,
  input  wire logic                  tx_done_in,
  output logic      [7:0]            tx_data_out,
  output logic                       tx_strobe_out,
  output logic                       tx_pending_out,
  output logic                       irq_out
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ----------------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------------
  if (DEPTH < 4 || DEPTH > 15)
  begin : g_bad_depth
    $error("DEPTH must lie between 4 and 15");
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic                    ack_reg;
  logic                    req;
  logic                    wr;
  logic                    rd;
  logic                    hit_level;
  logic                    hit_data;
  logic                    hit_irq;
  logic                    hit_ctrl;

  assign req       = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr        = req & wb_we_in & wb_sel_in[0];
  assign rd        = req & ~wb_we_in;
  assign hit_level = wb_adr_in[9:2] == `IDX_FIFO_LEVEL_CONTROL;
  assign hit_data  = wb_adr_in[9:2] == `IDX_SERIAL_DATA_PORT;
  assign hit_irq   = wb_adr_in[9:2] == `IDX_SERIAL_IRQ_STAT_EN;
  assign hit_ctrl  = wb_adr_in[9:2] == `IDX_CHANNEL_CONTROL;

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  logic                    chan_en_reg;
  logic [3:0]              rx_trig_reg;
  logic [3:0]              tx_trig_reg;
  logic [3:0]              wr_rx_code;
  logic [3:0]              wr_tx_code;

  assign wr_rx_code = wb_dat_in[`RX_FIELD_MSB:`RX_FIELD_LSB];
  assign wr_tx_code = wb_dat_in[`TX_FIELD_MSB:`TX_FIELD_LSB];

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      chan_en_reg <= `RST_CHANNEL_ENABLE;
    else if (wr && hit_ctrl)
      chan_en_reg <= wb_dat_in[`CHANNEL_ENABLE_BIT];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      rx_trig_reg <= 4'(`RST_LEVEL_CONTROL >> `RX_FIELD_LSB);
      tx_trig_reg <= 4'(`RST_LEVEL_CONTROL);
    end
    else if (wr && hit_level)
    begin
      if (wr_rx_code <= `RX_TRIG_MAX_CODE)
        rx_trig_reg <= wr_rx_code; // [R5]
      if (wr_tx_code >= `TX_TRIG_MIN_CODE && wr_tx_code <= `TX_TRIG_MAX_CODE)
        tx_trig_reg <= wr_tx_code; // [R6]
    end
  end

  // ----------------------------------------------------------------------
  // Receive queue
  // ----------------------------------------------------------------------
  logic [7:0]              rx_mem [DEPTH];
  logic [PW-1:0]           rx_wr_ptr;
  logic [PW-1:0]           rx_rd_ptr;
  logic [3:0]              rx_count_reg;
  logic                    rx_full;
  logic                    rx_empty;
  logic                    rx_push;
  logic                    rx_pop;
  logic [7:0]              rx_head;

  assign rx_full  = rx_count_reg == 4'(DEPTH);
  assign rx_empty = rx_count_reg == 4'h0;
  assign rx_push  = rx_byte_in.valid & chan_en_reg & ~rx_full;
  assign rx_pop   = rd & hit_data & chan_en_reg & ~rx_empty; // [R3]
  assign rx_head  = rx_mem[rx_rd_ptr];

  always_ff @(posedge ref_clk_in)
  begin
    if (rx_push)
      rx_mem[rx_wr_ptr] <= rx_byte_in.data;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || !chan_en_reg)
    begin
      rx_wr_ptr    <= '0; // [R1]
      rx_rd_ptr    <= '0;
      rx_count_reg <= 4'h0;
    end
    else
    begin
      if (rx_push)
        rx_wr_ptr <= (rx_wr_ptr == PW'(DEPTH - 1)) ? '0 : rx_wr_ptr + 1'b1;
      if (rx_pop)
        rx_rd_ptr <= (rx_rd_ptr == PW'(DEPTH - 1)) ? '0 : rx_rd_ptr + 1'b1;
      if (rx_push && !rx_pop)
        rx_count_reg <= rx_count_reg + 4'h1;
      else if (rx_pop && !rx_push)
        rx_count_reg <= rx_count_reg - 4'h1; // [R3]
    end
  end

  // ----------------------------------------------------------------------
  // Transmit queue
  // ----------------------------------------------------------------------
  logic [7:0]              tx_mem [DEPTH];
  logic [PW-1:0]           tx_wr_ptr;
  logic [PW-1:0]           tx_rd_ptr;
  logic [3:0]              tx_count_reg;
  logic [3:0]              tx_count_next;
  logic                    tx_full;
  logic                    tx_empty;
  logic                    tx_push;
  logic                    tx_pop;

  assign tx_full  = tx_count_reg == 4'(DEPTH);
  assign tx_empty = tx_count_reg == 4'h0;
  assign tx_push  = wr & hit_data & chan_en_reg & ~tx_full; // [R4]
  assign tx_pop   = tx_take_in & chan_en_reg & ~tx_empty;

  always_comb
  begin
    tx_count_next = tx_count_reg;
    if (!chan_en_reg)
      tx_count_next = 4'h0;
    else if (tx_push && !tx_pop)
      tx_count_next = tx_count_reg + 4'h1;
    else if (tx_pop && !tx_push)
      tx_count_next = tx_count_reg - 4'h1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (tx_push)
      tx_mem[tx_wr_ptr] <= wb_dat_in[7:0]; // [R4]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in || !chan_en_reg)
    begin
      tx_wr_ptr    <= '0; // [R1]
      tx_rd_ptr    <= '0;
      tx_count_reg <= 4'h0;
    end
    else
    begin
      if (tx_push)
        tx_wr_ptr <= (tx_wr_ptr == PW'(DEPTH - 1)) ? '0 : tx_wr_ptr + 1'b1;
      if (tx_pop)
        tx_rd_ptr <= (tx_rd_ptr == PW'(DEPTH - 1)) ? '0 : tx_rd_ptr + 1'b1;
      tx_count_reg <= tx_count_next;
    end
  end

  // Byte handed to the shifter
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      tx_data_out    <= 8'h00;
      tx_strobe_out  <= 1'b0;
      tx_pending_out <= 1'b0;
    end
    else
    begin
      if (tx_pop)
        tx_data_out <= tx_mem[tx_rd_ptr];
      tx_strobe_out  <= tx_pop;
      tx_pending_out <= tx_count_next != 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------------
  uart_fifo_pkg::irq_bits_s en_reg;
  uart_fifo_pkg::irq_bits_s wr_en;
  uart_fifo_pkg::irq_bits_s status;
  logic [4:0]              flags_reg;
  logic [4:0]              flag_set;
  logic [4:0]              flag_clr;
  logic                    rx_avail_live;
  logic                    tx_room_live;

  assign wr_en         = uart_fifo_pkg::irq_bits_s'(wb_dat_in[7:0]);
  assign rx_avail_live = rx_count_reg > rx_trig_reg;
  assign tx_room_live  = tx_count_reg < tx_trig_reg;
  assign flag_set = {rx_byte_in.valid & chan_en_reg & rx_full,
                     rd & hit_data & rx_empty,
                     wr & hit_data & chan_en_reg & tx_full,
                     rx_byte_in.valid & rx_byte_in.frame_err,
                     tx_done_in};

  always_comb
  begin
    flag_clr = 5'h00;
    if (rd && hit_irq)
      flag_clr = 5'h1f;
    if (wr && hit_irq)
      flag_clr = flag_clr | ~{wr_en.rx_overflow_flag,
                              wr_en.rx_underflow_flag,
                              wr_en.tx_overflow_flag,
                              wr_en.framing_error_flag,
                              wr_en.tx_complete_flag};
    if (!chan_en_reg)
      flag_clr = flag_clr | 5'h1c; // [R2]
  end

  assign status = {en_reg.irq_master_enable, tx_room_live, rx_avail_live,
                   flags_reg};

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      flags_reg <= 5'(`RST_IRQ_STAT_EN);
    else
      flags_reg <= (flags_reg & ~flag_clr) | flag_set; // [R2]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      en_reg <= uart_fifo_pkg::irq_bits_s'(`RST_IRQ_STAT_EN);
    else if (wr && hit_irq)
      en_reg <= wr_en;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
      irq_out <= 1'b0;
    else
      irq_out <= en_reg.irq_master_enable &
                 (|(status[6:0] & en_reg[6:0])); // [R8]
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      ack_reg    <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= req;
      if (rd)
      begin
        if (hit_level)
          wb_dat_out <= {24'h00_0000, rx_count_reg, tx_count_reg}; // [R7]
        else if (hit_data)
          wb_dat_out <= {24'h00_0000,
                         rx_empty ? `RST_DATA_PORT : rx_head}; // [R3]
        else if (hit_irq)
          wb_dat_out <= {24'h00_0000, status};
        else if (hit_ctrl)
          wb_dat_out <= {24'h00_0000, chan_en_reg, 7'h00};
        else
          wb_dat_out <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_out = ack_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_req;
    req;
  endsequence
  sequence s_ack_pulse;
    ack_reg ##1 !ack_reg;
  endsequence

  property p_bus_ack;
    s_req |=> s_ack_pulse;
  endproperty
  a_bus_ack: assert property (p_bus_ack)
    else $error("ack not a one cycle answer");

  property p_queue_clear;
    !chan_en_reg |=> rx_count_reg == 4'h0 && tx_count_reg == 4'h0;
  endproperty
  a_queue_clear: assert property (p_queue_clear) // [R1]
    else $error("queues not emptied while disabled");

  property p_flag_clear;
    (!chan_en_reg && flag_set[4:2] == 3'h0) |=> flags_reg[4:2] == 3'h0;
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [R2]
    else $error("fifo flags kept while disabled");

  property p_rx_read;
    (rx_pop && !rx_push) |=>
      rx_count_reg == $past(rx_count_reg) - 4'h1 &&
      wb_dat_out[7:0] == $past(rx_head);
  endproperty
  a_rx_read: assert property (p_rx_read) // [R3]
    else $error("rx read did not return and remove head");

  property p_tx_write;
    (tx_push && !tx_pop) |=> tx_count_reg == $past(tx_count_reg) + 4'h1;
  endproperty
  a_tx_write: assert property (p_tx_write) // [R4]
    else $error("tx write not queued");

  property p_rx_trig;
    (wr && hit_level && wr_rx_code > `RX_TRIG_MAX_CODE) |=>
      $stable(rx_trig_reg);
  endproperty
  a_rx_trig: assert property (p_rx_trig) // [R5]
    else $error("reserved rx trigger code taken");

  property p_tx_trig;
    (wr && hit_level && (wr_tx_code == 4'h0 ||
                         wr_tx_code > `TX_TRIG_MAX_CODE)) |=>
      $stable(tx_trig_reg);
  endproperty
  a_tx_trig: assert property (p_tx_trig) // [R6]
    else $error("reserved tx trigger code taken");

  property p_count_ro;
    (wr && hit_level && !rx_push && !tx_pop && chan_en_reg) |=>
      $stable(rx_count_reg) && $stable(tx_count_reg);
  endproperty
  a_count_ro: assert property (p_count_ro) // [R7]
    else $error("fill count changed by write");

  property p_irq_gate;
    !en_reg.irq_master_enable |=> !irq_out;
  endproperty
  a_irq_gate: assert property (p_irq_gate) // [R8]
    else $error("irq without master enable");

  property p_irq_set;
    (en_reg.irq_master_enable && en_reg.tx_complete_flag &&
     flags_reg[0]) |=> irq_out;
  endproperty
  a_irq_set: assert property (p_irq_set) // [R8]
    else $error("enabled flag did not raise irq");

endmodule // uart_fifo_irq_frontend

// ---- uart_fifo_cfg.svh ----
// Offsets, field positions, reset values and codes of the FIFO front end
`ifndef UART_FIFO_CFG_SVH
`define UART_FIFO_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_FIFO_LEVEL_CONTROL   8'h96
`define IDX_SERIAL_DATA_PORT     8'h97
`define IDX_SERIAL_IRQ_STAT_EN   8'h9a
`define IDX_CHANNEL_CONTROL      8'h9c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RX_FIELD_MSB             7
`define RX_FIELD_LSB             4
`define TX_FIELD_MSB             3
`define TX_FIELD_LSB             0
`define CHANNEL_ENABLE_BIT       7

// ----------------------------------------------------------------------
// Trigger code limits
// ----------------------------------------------------------------------
`define RX_TRIG_MAX_CODE         4'h3
`define TX_TRIG_MIN_CODE         4'h1
`define TX_TRIG_MAX_CODE         4'h4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_LEVEL_CONTROL        8'h00
`define RST_IRQ_STAT_EN          8'h00
`define RST_CHANNEL_ENABLE       1'b0
`define RST_DATA_PORT            8'h00

`endif

// ---- uart_fifo_pkg.sv ----
// Types shared by the FIFO front end
package uart_fifo_pkg;

  // Interrupt register layout, status on read, enables on write
  typedef struct packed {
    logic irq_master_enable;
    logic tx_room_available_flag;
    logic rx_data_available_flag;
    logic rx_overflow_flag;
    logic rx_underflow_flag;
    logic tx_overflow_flag;
    logic framing_error_flag;
    logic tx_complete_flag;
  } irq_bits_s;

  // Byte from the serial shifter
  typedef struct packed {
    logic       valid;
    logic       frame_err;
    logic [7:0] data;
  } rx_byte_s;

endpackage

// ---- uart_shifter_model.sv ----
// Behavioural serial shifter on the far side of the FIFO front end
`timescale 1ns/1ps

module uart_shifter_model (
  input  wire logic               ref_clk_in,
  output uart_fifo_pkg::rx_byte_s rx_byte_out,
  output logic                    tx_take_out,
  output logic                    tx_done_out,
  input  wire logic [7:0]         tx_data_in,
  input  wire logic               tx_strobe_in
);
  initial
  begin
    rx_byte_out = '0;
    tx_take_out = 1'b0;
    tx_done_out = 1'b0;
  end

  // Received byte; data inverted outside the pulse
  task automatic send_rx(input logic [7:0] d, input logic fe);
    @(posedge ref_clk_in);
    rx_byte_out <= {1'b1, fe, d};
    @(posedge ref_clk_in);
    rx_byte_out <= {1'b0, ~fe, ~d};
  endtask

  // Ask for a byte, capture it, report completion
  task automatic take_tx(output logic [7:0] d, output logic s);
    @(posedge ref_clk_in);
    tx_take_out <= 1'b1;
    @(posedge ref_clk_in);
    tx_take_out <= 1'b0;
    @(posedge ref_clk_in);
    d = tx_data_in;
    s = tx_strobe_in;
    tx_done_out <= 1'b1;
    @(posedge ref_clk_in);
    tx_done_out <= 1'b0;
  endtask
endmodule // uart_shifter_model

// ---- testbench.sv ----
// Register-level testbench of the FIFO front end
`timescale 1ns/1ps

module testbench;
  logic                    clk;
  logic                    rst_b;
  logic                    cyc;
  logic                    we;
  logic [9:0]              adr;
  logic [31:0]             wdat;
  logic [31:0]             rdat;
  logic                    ack;
  uart_fifo_pkg::rx_byte_s rxb;
  logic                    take;
  logic                    done;
  logic [7:0]              txd;
  logic                    txs;
  logic                    pend;
  logic                    irq;
  int                      miscompares;
  int                      comparisons;
  logic [7:0]              b;
  logic                    s;

  uart_fifo_irq_frontend #(.DEPTH(4)) i_dut (
    .ref_clk_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .rx_byte_in(rxb),
    .tx_take_in(take), .tx_done_in(done), .tx_data_out(txd),
    .tx_strobe_out(txs), .tx_pending_out(pend), .irq_out(irq)
  );

  uart_shifter_model i_model (
    .ref_clk_in(clk), .rx_byte_out(rxb), .tx_take_out(take),
    .tx_done_out(done), .tx_data_in(txd), .tx_strobe_in(txs)
  );

  // ------------------------------------------------------------
  // Clock, reset, watchdog
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #400000;
    miscompares++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e,
                       input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // Classic single Wishbone cycle
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    do
    begin
      @(posedge clk);
      n++;
      if (n > 50)
      begin
        miscompares++;
        wrap_up();
      end
    end while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 8'h00, r);
    check($sformatf("read %h", a), {24'h00_0000, e}, r);
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    check("irq_out", {31'h0000_0000, e}, {31'h0000_0000, irq});
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    adr = 10'h000;
    wdat = 32'h0000_0000;
    miscompares = 0;
    comparisons = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    // Reset values and an unmapped place
    rd(10'h258, 8'h00);
    rd(10'h268, 8'h00);
    rd(10'h270, 8'h00);
    wr(10'h3fc, 8'h5a);
    rd(10'h3fc, 8'h00);
    wr(10'h270, 8'h80);
    rd(10'h270, 8'h80);
    // Valid triggers, then reserved codes that must not stick
    wr(10'h258, 8'h23);
    wr(10'h258, 8'h85);
    for (int i = 0; i < 5; i++)
      wr(10'h25c, 8'ha0 + 8'(i));
    rd(10'h258, 8'h04);
    check("tx pending", 32'h0000_0001, {31'h0000_0000, pend});
    wr(10'h258, 8'hff);
    rd(10'h258, 8'h04);
    rd(10'h268, 8'h04);
    rd(10'h268, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      i_model.take_tx(b, s);
      check("tx byte", {24'h00_0000, 8'ha0 + 8'(i)}, {24'h00_0000, b});
      check("tx strobe", 32'h0000_0001, {31'h0000_0000, s});
    end
    check("tx pending", 32'h0000_0000, {31'h0000_0000, pend});
    rd(10'h268, 8'h41);
    // Receive path and interrupt gating
    i_model.send_rx(8'h11, 1'b0);
    i_model.send_rx(8'h22, 1'b0);
    i_model.send_rx(8'h33, 1'b0);
    rd(10'h258, 8'h30);
    wr(10'h268, 8'ha0);
    irq_chk(1'b1);
    wr(10'h268, 8'h20);
    irq_chk(1'b0);
    wr(10'h268, 8'he0);
    irq_chk(1'b1);
    wr(10'h268, 8'h90);
    irq_chk(1'b0);
    wr(10'h268, 8'h00);
    rd(10'h268, 8'h60);
    rd(10'h25c, 8'h11);
    rd(10'h25c, 8'h22);
    rd(10'h25c, 8'h33);
    rd(10'h25c, 8'h00);
    rd(10'h268, 8'h48);
    // Overflow both queues, then clear through the channel enable
    for (int i = 0; i < 5; i++)
      i_model.send_rx(8'h40 + 8'(i), i == 4);
    for (int i = 0; i < 5; i++)
      wr(10'h25c, 8'hc0 + 8'(i));
    rd(10'h258, 8'h44);
    wr(10'h270, 8'h00);
    wr(10'h270, 8'h80);
    rd(10'h258, 8'h00);
    rd(10'h268, 8'h42);
    wrap_up();
  end
endmodule // testbench
